// File: rtl/status_byte_map.svh
// field positions, live bit mask and enable reset value of the status byte block
`ifndef STATUS_BYTE_MAP_SVH
`define STATUS_BYTE_MAP_SVH
`define SB_BIT_MASTER    6
`define SB_BIT_EVENT     5
`define SB_BIT_MSG_AVAIL 4
`define SB_BIT_QUES      3
`define SB_BIT_CHANNEL   2
`define SB_LIVE_MASK     8'h3C
`define SRE_RESET        8'h00
`endif

// File: rtl/status_byte_pkg.sv
// types shared by the status byte block
package status_byte_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {
    CMD_IDLE      = 3'b001,
    CMD_SRE_WRITE = 3'b010,
    CMD_READ      = 3'b100
  } cmd_t;
endpackage : status_byte_pkg

// File: rtl/status_summary_comb.sv
// combinational assembly of the status byte and its master summary bit
`timescale 1ns/10ps
`default_nettype none
`include "status_byte_map.svh"
module status_summary_comb (
  input  wire  status_byte_pkg::byte_t enable_mask,
  input  wire  logic                   event_summary,
  input  wire  logic                   msg_avail,
  input  wire  logic                   ques_summary,
  input  wire  logic                   channel_summary_bit,
  output logic                         master_summary,
  output status_byte_pkg::byte_t       status_value
);
  import status_byte_pkg::*;
  byte_t raw;
  always_comb begin
    raw = 8'h00;
    raw[`SB_BIT_EVENT]     = event_summary;
    raw[`SB_BIT_MSG_AVAIL] = msg_avail;
    raw[`SB_BIT_QUES]      = ques_summary;
    raw[`SB_BIT_CHANNEL]   = channel_summary_bit;
    // bit 6 of the enable cannot feed itself; only live bits count
    master_summary = |(raw & enable_mask & `SB_LIVE_MASK);
    status_value = raw;
    status_value[`SB_BIT_MASTER] = master_summary;
  end
endmodule : status_summary_comb
`default_nettype wire

// File: rtl/service_request_status_byte.sv
// service request enable register and status byte read port
//
// Notes on behaviour
// - enable write loads eight-bit value 0..255
// - master summary is OR of enabled bits
// - enable query returns current enable contents
// - status read shows master summary in bit 6
// - status read clears nothing
// - fixed bit layout, bits 7,1,0 zero
`timescale 1ns/10ps
`default_nettype none
`include "status_byte_map.svh"
module service_request_status_byte (
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  input  wire logic                    sre_write,
  input  wire status_byte_pkg::byte_t  sre_wdata,
  input  wire logic                    sre_query,
  input  wire logic                    stb_query,
  input  wire logic                    event_summary,
  input  wire logic                    msg_avail,
  input  wire logic                    ques_summary,
  input  wire logic                    channel_summary_bit,
  output status_byte_pkg::byte_t       rdata,
  output logic                         rvalid,
  output logic                         master_summary
);
  import status_byte_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  byte_t sre_q, sre_d;
  byte_t rdata_q, rdata_d;
  logic  rvalid_q, rvalid_d;
  logic  mss_q;
  logic  mss_now;
  byte_t stb_now;

  status_summary_comb u_sum (
    .enable_mask         (sre_q),
    .event_summary       (event_summary),
    .msg_avail           (msg_avail),
    .ques_summary        (ques_summary),
    .channel_summary_bit (channel_summary_bit),
    .master_summary      (mss_now),
    .status_value        (stb_now)
  );

  // ----------------------------------------
  // command handling
  // ----------------------------------------
  always_comb begin
    sre_d    = sre_q;
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    if (sre_write) begin
      sre_d = sre_wdata;
    end
    if (sre_query) begin
      rdata_d  = sre_q;
      rvalid_d = 1'b1;
    end else if (stb_query) begin
      // a read only samples; status bits fall only with their sources
      rdata_d  = stb_now;
      rvalid_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sre_q    <= `SRE_RESET;
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
      mss_q    <= 1'b0;
    end else begin
      sre_q    <= sre_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      mss_q    <= mss_now;
    end
  end

  assign rdata          = rdata_q;
  assign rvalid         = rvalid_q;
  assign master_summary = mss_q;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // live status bits in their byte positions, for the checks below
  function automatic byte_t live_bits(input logic e,
                                      input logic m,
                                      input logic q,
                                      input logic c);
    byte_t b;
    b = 8'h00;
    b[`SB_BIT_EVENT]     = e;
    b[`SB_BIT_MSG_AVAIL] = m;
    b[`SB_BIT_QUES]      = q;
    b[`SB_BIT_CHANNEL]   = c;
    return b;
  endfunction : live_bits

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_sre_load: assert property (@(posedge sys_clk) disable iff (!nrst)
    sre_write |=> sre_q == $past(sre_wdata))
    else $error("enable register not loaded");

  a_sre_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    !sre_write |=> $stable(sre_q))
    else $error("enable register changed without write");

  a_sre_readback: assert property (@(posedge sys_clk) disable iff (!nrst)
    sre_query |=> rvalid && rdata == $past(sre_q))
    else $error("enable query wrong");

  a_query_prio: assert property (@(posedge sys_clk) disable iff (!nrst)
    (sre_query && stb_query) |=> rdata == $past(sre_q))
    else $error("enable query lost priority");

  a_idle_novalid: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!sre_query && !stb_query) |=> !rvalid)
    else $error("read valid without query");

  a_stb_valid: assert property (@(posedge sys_clk) disable iff (!nrst)
    (stb_query && !sre_query) |=> rvalid)
    else $error("status query not answered");

  a_mss_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
    (stb_query && !sre_query) |=> rdata[6] == $past(mss_now))
    else $error("status bit 6 not master summary");

  a_zero_bits: assert property (@(posedge sys_clk) disable iff (!nrst)
    (stb_query && !sre_query) |=> rdata[7] == 1'b0 && rdata[1:0] == 2'b00
      && rdata[2] == $past(channel_summary_bit) && rdata[5] == $past(event_summary))
    else $error("status layout wrong");

  a_live_layout: assert property (@(posedge sys_clk) disable iff (!nrst)
    (stb_query && !sre_query) |=> (rdata & `SB_LIVE_MASK)
      == $past(live_bits(event_summary, msg_avail, ques_summary, channel_summary_bit)))
    else $error("live status bits misplaced");

  a_mss_or: assert property (@(posedge sys_clk) disable iff (!nrst)
    ##1 master_summary == $past(|(sre_q & `SB_LIVE_MASK
      & live_bits(event_summary, msg_avail, ques_summary, channel_summary_bit))))
    else $error("master summary wrong");

  a_mss_event: assert property (@(posedge sys_clk) disable iff (!nrst)
    (event_summary && sre_q[`SB_BIT_EVENT]) |-> mss_now)
    else $error("enabled event summary not in master");

  a_mss_ques: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ques_summary && sre_q[`SB_BIT_QUES]) |-> mss_now)
    else $error("enabled questionable summary not in master");

  a_mss_chan: assert property (@(posedge sys_clk) disable iff (!nrst)
    (channel_summary_bit && sre_q[`SB_BIT_CHANNEL]) |-> mss_now)
    else $error("enabled channel summary not in master");

  a_mss_none: assert property (@(posedge sys_clk) disable iff (!nrst)
    ((live_bits(event_summary, msg_avail, ques_summary, channel_summary_bit)
      & sre_q) == 8'h00) |-> !mss_now)
    else $error("master summary set with no enabled source");

  a_bit6_ignored: assert property (@(posedge sys_clk) disable iff (!nrst)
    ((sre_q & `SB_LIVE_MASK) == 8'h00) |-> !mss_now)
    else $error("dead enable bits reach master summary");

  a_no_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
    stb_query && !sre_write |=> sre_q == $past(sre_q))
    else $error("status read disturbed state");

  a_read_keeps_mss: assert property (@(posedge sys_clk) disable iff (!nrst)
    stb_query |=> master_summary == $past(mss_now))
    else $error("status read disturbed summary");

  a_rdata_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!sre_query && !stb_query) |=> $stable(rdata))
    else $error("read data changed without query");

  a_mss_live: assert property (@(posedge sys_clk) disable iff (!nrst)
    (msg_avail && sre_q[4]) |-> mss_now)
    else $error("summary stale");

  // reset checks run without the disable so the reset edge itself is seen
  a_reset_sre: assert property (@(posedge sys_clk)
    !nrst |=> sre_q == `SRE_RESET)
    else $error("enable register not reset");

  a_reset_out: assert property (@(posedge sys_clk)
    !nrst |=> !rvalid && !master_summary && rdata == 8'h00)
    else $error("outputs not reset");
endmodule : service_request_status_byte
`default_nettype wire

// File: tb/bus_ctrl_model.sv
// remote controller model issuing enable writes and queries
`timescale 1ns/10ps
`default_nettype none
module bus_ctrl_model (
  input  wire logic             clk,
  output logic                  wr,
  output status_byte_pkg::byte_t wd,
  output logic                  sq,
  output logic                  bq
);
  import status_byte_pkg::*;
  initial begin
    {wr, sq, bq} = '0;
    wd = 8'h00;
  end
  // one strobe held for one edge
  task automatic issue(input int kind, input byte_t v);
    @(posedge clk) #1;
    wr = (kind == 0);
    wd = v;
    sq = (kind == 1);
    bq = (kind == 2);
    @(posedge clk) #1;
    {wr, sq, bq} = '0;
    wd = ~v; // released data must not look valid
  endtask : issue
endmodule : bus_ctrl_model
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the status byte block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import status_byte_pkg::*;
  logic sys_clk = 0, nrst = 0, es = 0, ma = 0, qs = 0, cs = 0, mss;
  logic wr, sq, bq, rvalid, master_summary;
  byte_t wd, rdata, v, st, en_m = 8'h00;
  int bad_count = 0, compares = 0, k, kind;
  logic [31:0] seed = 32'd13113;
  always #20 sys_clk = ~sys_clk;
  bus_ctrl_model u_ctrl (.clk(sys_clk), .wr(wr), .wd(wd), .sq(sq), .bq(bq));
  service_request_status_byte u_dut (.sys_clk(sys_clk), .nrst(nrst), .sre_write(wr),
    .sre_wdata(wd), .sre_query(sq), .stb_query(bq), .event_summary(es),
    .msg_avail(ma), .ques_summary(qs), .channel_summary_bit(cs), .rdata(rdata),
    .rvalid(rvalid), .master_summary(master_summary));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  task automatic check(input byte_t seen, input byte_t want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic give_verdict;
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  // ----------
  // main run
  // ----------
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 nrst = 1;
    for (k = 0; k < 80; k++) begin
      seed = xs(seed);
      {es, ma, qs, cs} = seed[3:0];
      kind = (k < 2) ? 0 : seed[5:4] % 3;
      v = (k < 2) ? {8{k[0]}} : seed[15:8];
      u_ctrl.issue(kind, v);
      st = {2'b00, es, ma, qs, cs, 2'b00};
      mss = |(st & en_m & 8'h3C);
      check({7'h00, rvalid}, {7'h00, kind != 0});
      check({7'h00, master_summary}, {7'h00, mss});
      if (kind == 1) check(rdata, en_m);
      if (kind == 2) check(rdata, st | {1'b0, mss, 6'h00});
      if (kind == 0) en_m = v;
    end
    // mid-run reset: outputs and enable return to their reset state
    @(posedge sys_clk) #1 nrst = 0;
    repeat (2) @(posedge sys_clk);
    #1 check(rdata, 8'h00);
    check({7'h00, rvalid}, 8'h00);
    check({7'h00, master_summary}, 8'h00);
    nrst = 1;
    en_m = 8'h00;
    u_ctrl.issue(1, 8'h5A);
    check(rdata, en_m);
    check({7'h00, rvalid}, 8'h01);
    give_verdict();
  end
  // hang guard well past the 177-cycle run
  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
